//--- logic/amp_device.sv
// Function
// - Strap low: pins form serial register port
// - Strap high: pins are static mode levels
// - Rising positive encode starts both channels
// - Falling negative encode never starts a conversion (its term is masked by single_end); grounded: single-ended
// - Shift only while chip select low
// - Capture data on rising serial clock
// - Readback bits valid at falling clock
// - Data out only pulls low, open drain
// - Parallel: select/clock levels pick lane count
// - Parallel: data in level is power-down
// - Parallel: data out level picks drive current
// - Two's complement output format offered
// - Sample sent 1, 2 or 4 bits per interval
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "amp_defs.svh"
module amp_device
(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  amp_port_if.device       port,
  input  wire logic        i_programming_mode_strap,
  input  wire logic        i_encode_clock_pos,
  input  wire logic        i_encode_clock_neg,
  input  wire logic [15:0] i_sample_ch1,
  input  wire logic [15:0] i_sample_ch2,
  output logic             o_sdo,
  output logic             o_sdo_oe_n,
  output logic             o_conv_start,
  output logic             o_single_ended,
  output logic             o_power_down,
  output logic [1:0]       o_lanes,
  output logic             o_drive_half,
  output logic             o_twos_comp,
  output logic [3:0]       o_lane_ch1,
  output logic [3:0]       o_lane_ch2,
  output logic             o_lane_valid
);
  localparam int SB = `AMP_SAMPLE_BITS;

  // All pins come from outside the clock domain
  logic [6:0] pin_s;
  amp_sync #(.WIDTH(7)) u_sync
  (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async ({i_programming_mode_strap, port.cs_n, port.sck, port.sdi,
               port.sdo, i_encode_clock_pos, i_encode_clock_neg}),
    .o_sync  (pin_s)
  );
  wire strap_s = pin_s[6];
  wire cs_n_s  = pin_s[5];
  wire sck_s   = pin_s[4];
  wire sdi_s   = pin_s[3];
  wire sdo_s   = pin_s[2];
  wire encp_s  = pin_s[1];
  wire encn_s  = pin_s[0];

  logic                      sck_prev_q, encp_prev_q, encn_prev_q;
  logic [4:0]                bit_cnt_q;
  logic [`AMP_FRAME_BITS-2:0] shift_q;
  logic                      read_q;
  logic [`AMP_DATA_BITS-1:0] rd_byte_q;
  logic                      sdo_q;
  logic [`AMP_DATA_BITS-1:0] power_q, outmode_q, format_q;
  logic [SB-1:0]             ser1_q, ser2_q;
  logic [4:0]                ser_left_q;

  // Edge and mode decode
  wire serial_mode = !strap_s;
  wire sck_rise    = serial_mode && !cs_n_s && sck_s && !sck_prev_q;
  wire sck_fall    = serial_mode && !cs_n_s && !sck_s && sck_prev_q;
  wire single_end  = !encn_s;
  wire enc_start   = (encp_s && !encp_prev_q) ||
                     (!single_end && !encn_s && encn_prev_q);
  wire last_bit    = bit_cnt_q == 5'(`AMP_FRAME_BITS - 1);
  wire [6:0] addr  = shift_q[`AMP_FRAME_BITS-3 -: `AMP_ADDR_BITS];
  wire [14:0] shifted = {shift_q[13:0], sdi_s};
  // Eighth rise: read flag at bit 7, address in the low seven bits
  wire [6:0] addr_now = shifted[6:0];
  wire [7:0] reg_rd =
    (addr_now == `AMP_REG_POWER)   ? power_q   :
    (addr_now == `AMP_REG_OUTMODE) ? outmode_q :
    (addr_now == `AMP_REG_FORMAT)  ? format_q  : `AMP_ZERO_BYTE;
  // Parallel mode levels, else register fields
  wire [1:0] lanes_d = serial_mode ?
    outmode_q[`AMP_OUTMODE_LANE_LSB +: 2] :
    ({cs_n_s, sck_s} == 2'h0 ? 2'(amp_pkg::AMP_LANE_1) :
     {cs_n_s, sck_s} == 2'h1 ? 2'(amp_pkg::AMP_LANE_2) :
                               2'(amp_pkg::AMP_LANE_4));
  wire pd_d  = serial_mode ? power_q[`AMP_POWER_DOWN_BIT] : sdi_s;
  wire drv_d = serial_mode ? outmode_q[`AMP_OUTMODE_DRV_BIT] : sdo_s;
  wire [4:0] step = (o_lanes == 2'(amp_pkg::AMP_LANE_4)) ? 5'h04 :
                    (o_lanes == 2'(amp_pkg::AMP_LANE_2)) ? 5'h02 : 5'h01;

  // Edge history
  always_ff @(posedge i_clk)
  begin
    sck_prev_q  <= i_reset ? 1'b0 : sck_s;
    encp_prev_q <= i_reset ? 1'b0 : encp_s;
    encn_prev_q <= i_reset ? 1'b0 : encn_s;
  end

  // Serial frame shifter; select high aborts a frame
  always_ff @(posedge i_clk)
  begin
    if (i_reset || cs_n_s || !serial_mode)
    begin
      bit_cnt_q <= 5'h00;
      shift_q   <= '0;
      read_q    <= 1'b0;
      rd_byte_q <= `AMP_ZERO_BYTE;
    end
    else if (sck_rise)
    begin
      shift_q   <= shifted;
      bit_cnt_q <= last_bit ? 5'h00 : bit_cnt_q + 5'h01;
      if (bit_cnt_q == 5'h00)
        read_q <= sdi_s;
      if (bit_cnt_q == 5'h07)
        rd_byte_q <= reg_rd;
      else if (bit_cnt_q > 5'h07)
        rd_byte_q <= {rd_byte_q[6:0], 1'b1};
    end
  end

  // Register writes on the last rising edge
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      power_q   <= `AMP_ZERO_BYTE;
      outmode_q <= `AMP_OUTMODE_RESET;
      format_q  <= `AMP_ZERO_BYTE;
    end
    else if (sck_rise && last_bit && !read_q)
    begin
      if (addr == `AMP_REG_RESET && sdi_s)
      begin
        power_q   <= `AMP_ZERO_BYTE;
        outmode_q <= `AMP_OUTMODE_RESET;
        format_q  <= `AMP_ZERO_BYTE;
      end
      else if (addr == `AMP_REG_POWER)
        power_q <= shifted[7:0];
      else if (addr == `AMP_REG_OUTMODE)
        outmode_q <= shifted[7:0];
      else if (addr == `AMP_REG_FORMAT)
        format_q <= shifted[7:0];
    end
  end

  // Readback: change after falling edge, pull low only
  always_ff @(posedge i_clk)
  begin
    if (i_reset || cs_n_s)
      sdo_q <= 1'b1;
    else if (sck_fall && read_q && bit_cnt_q >= 5'h08)
      sdo_q <= rd_byte_q[7];
  end
  assign port.sdo_dev_o    = 1'b0;
  assign port.sdo_dev_oe_n = sdo_q;

  // Conversion start and mode outputs
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_sdo          <= 1'b1;
      o_sdo_oe_n     <= 1'b1;
      o_conv_start   <= 1'b0;
      o_single_ended <= 1'b0;
      o_power_down   <= 1'b0;
      o_lanes        <= 2'(amp_pkg::AMP_LANE_1);
      o_drive_half   <= 1'b0;
      o_twos_comp    <= 1'b0;
    end
    else
    begin
      o_sdo          <= 1'b0;
      o_sdo_oe_n     <= sdo_q;
      o_conv_start   <= enc_start && !pd_d;
      o_single_ended <= single_end;
      o_power_down   <= pd_d;
      o_lanes        <= lanes_d;
      o_drive_half   <= drv_d;
      o_twos_comp    <= serial_mode && format_q[`AMP_FORMAT_TWOS_BIT];
    end
  end

  // Serializer: both channels from the same start
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      ser1_q       <= '0;
      ser2_q       <= '0;
      ser_left_q   <= 5'h00;
      o_lane_ch1   <= 4'h0;
      o_lane_ch2   <= 4'h0;
      o_lane_valid <= 1'b0;
    end
    else if (o_conv_start)
    begin
      // Offset binary flips MSB; two's complement passes raw
      ser1_q     <= o_twos_comp ? i_sample_ch1 : {~i_sample_ch1[15], i_sample_ch1[14:0]};
      ser2_q     <= o_twos_comp ? i_sample_ch2 : {~i_sample_ch2[15], i_sample_ch2[14:0]};
      ser_left_q <= 5'(SB);
      o_lane_valid <= 1'b0;
    end
    else if (ser_left_q != 5'h00)
    begin
      o_lane_ch1   <= ser1_q[SB-1 -: 4] >> (3'h4 - 3'(step));
      o_lane_ch2   <= ser2_q[SB-1 -: 4] >> (3'h4 - 3'(step));
      ser1_q       <= ser1_q << step;
      ser2_q       <= ser2_q << step;
      ser_left_q   <= ser_left_q - step;
      o_lane_valid <= 1'b1;
    end
    else
      o_lane_valid <= 1'b0;
  end
endmodule

//--- logic/amp_defs.svh
`ifndef AMP_DEFS_SVH
`define AMP_DEFS_SVH

// Serial frame: read flag, 7-bit address, 8-bit data
`define AMP_FRAME_BITS   16
`define AMP_ADDR_BITS    7
`define AMP_DATA_BITS    8
`define AMP_REG_COUNT    5
// Register addresses of the mode control bank
`define AMP_REG_RESET    7'h00
`define AMP_REG_POWER    7'h01
`define AMP_REG_TIMING   7'h02
`define AMP_REG_OUTMODE  7'h03
`define AMP_REG_FORMAT   7'h04
// Field positions
`define AMP_POWER_DOWN_BIT   0
`define AMP_OUTMODE_LANE_LSB 0
`define AMP_OUTMODE_DRV_BIT  2
`define AMP_FORMAT_TWOS_BIT  0
// Reset values
`define AMP_OUTMODE_RESET 8'h01
`define AMP_ZERO_BYTE     8'h00
// Sample width and host clock divider
`define AMP_SAMPLE_BITS  16
`define AMP_SCK_HALF     4

`endif

//--- logic/amp_pkg.sv
package amp_pkg;
  typedef enum logic [1:0]
  {
    AMP_LANE_1 = 2'h0,
    AMP_LANE_2 = 2'h1,
    AMP_LANE_4 = 2'h2
  } amp_lane_t;

  typedef enum logic [1:0]
  {
    AMP_H_IDLE  = 2'h0,
    AMP_H_LOW   = 2'h1,
    AMP_H_HIGH  = 2'h3,
    AMP_H_DONE  = 2'h2
  } amp_host_state_t;
endpackage

//--- logic/amp_port_if.sv
`timescale 1ns/1ps
interface amp_port_if;
  logic cs_n;
  logic sck;
  logic sdi;
  logic sdo_host_o;
  logic sdo_host_oe_n;
  logic sdo_dev_o;
  logic sdo_dev_oe_n;
  // Open drain wire with pull-up: low if any end pulls
  wire  sdo = !((!sdo_dev_oe_n && !sdo_dev_o) ||
                (!sdo_host_oe_n && !sdo_host_o));

  modport device
  (
    input  cs_n,
    input  sck,
    input  sdi,
    input  sdo,
    output sdo_dev_o,
    output sdo_dev_oe_n
  );
  modport host
  (
    output cs_n,
    output sck,
    output sdi,
    input  sdo,
    output sdo_host_o,
    output sdo_host_oe_n
  );
endinterface

//--- logic/amp_sync.sv
`timescale 1ns/1ps
module amp_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;

  // Two stages; only the second is read outside
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      meta_q <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

//--- logic/amp_host.sv
`timescale 1ns/1ps
`include "amp_defs.svh"
module amp_host
(
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  amp_port_if.host        port,
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata
);
  // Regs: 0 cmd {rd,addr}, 1 wdata, 2 go (write) / rdback (read), 3 status {busy}
  amp_pkg::amp_host_state_t st_q;
  logic [7:0]  cmd_q, wd_q, rb_q;
  logic [15:0] sh_q;
  logic [4:0]  n_q;
  logic [2:0]  div_q;
  logic        cs_q, sck_q;
  logic        sdo_m, sdo_s;
  wire tick = div_q == 3'(`AMP_SCK_HALF - 1);

  // Two-flop sample of the open-drain line
  always_ff @(posedge i_clk)
  begin
    sdo_m <= i_reset ? 1'b1 : port.sdo;
    sdo_s <= i_reset ? 1'b1 : sdo_m;
  end

  assign port.cs_n          = cs_q;
  assign port.sck           = sck_q;
  assign port.sdi           = sh_q[15];
  assign port.sdo_host_o    = 1'b1;
  assign port.sdo_host_oe_n = 1'b1;

  // Register port, read data one cycle later
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_rdata <= 8'h00;
    else if (i_rd)
      o_rdata <= i_addr == 2'h0 ? cmd_q : i_addr == 2'h1 ? wd_q :
                 i_addr == 2'h3 ? {7'h00, st_q != amp_pkg::AMP_H_IDLE} : rb_q;
  end

  // Frame engine: select low whole frame, clock idles low
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      st_q <= amp_pkg::AMP_H_IDLE;
      cmd_q <= 8'h00; wd_q <= 8'h00; rb_q <= 8'h00;
      sh_q <= 16'h0000; n_q <= 5'h00; div_q <= 3'h0;
      cs_q <= 1'b1; sck_q <= 1'b0;
    end
    else
    begin
      if (i_wr && i_addr == 2'h0) cmd_q <= i_wdata;
      if (i_wr && i_addr == 2'h1) wd_q <= i_wdata;
      div_q <= tick ? 3'h0 : div_q + 3'h1;
      unique case (st_q)
        amp_pkg::AMP_H_IDLE:
          if (i_wr && i_addr == 2'h2)
          begin
            sh_q <= {cmd_q, wd_q};
            cs_q <= 1'b0;
            n_q  <= 5'h00;
            div_q <= 3'h0;
            st_q <= amp_pkg::AMP_H_LOW;
          end
        amp_pkg::AMP_H_LOW:
          if (tick)
          begin
            sck_q <= 1'b1;
            st_q  <= amp_pkg::AMP_H_HIGH;
          end
        amp_pkg::AMP_H_HIGH:
          if (tick)
          begin
            sck_q <= 1'b0;
            if (n_q >= 5'h08) rb_q <= {rb_q[6:0], sdo_s};
            sh_q <= {sh_q[14:0], 1'b0};
            n_q  <= n_q + 5'h01;
            st_q <= n_q == 5'h0F ? amp_pkg::AMP_H_DONE : amp_pkg::AMP_H_LOW;
          end
        amp_pkg::AMP_H_DONE:
          if (tick)
          begin
            cs_q <= 1'b1;
            st_q <= amp_pkg::AMP_H_IDLE;
          end
      endcase
    end
  end
endmodule

//--- testbench/amp_port_props.sv
`timescale 1ns/1ps
module amp_port_props
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_dev_o,
  input wire logic sdo_dev_oe_n,
  input wire logic sdo_host_o,
  input wire logic sdo_host_oe_n
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  // Wire discipline of the shared data out line
  open_drain_a: assert property (!sdo_dev_oe_n |-> !sdo_dev_o)
    else $error("device drove data out high");
  host_quiet_a: assert property (sdo_host_oe_n)
    else $error("host drove data out");
  dev_release_a: assert property (cs_n [*8] |-> sdo_dev_oe_n)
    else $error("device pulls data out while deselected");
  // Clock shape; the device ignores clock edges while deselected
  sck_park_a: assert property (cs_n && $past(cs_n) |-> !sck)
    else $error("serial clock moved while deselected");
  sck_high_a: assert property ($rose(sck) |-> sck [*4])
    else $error("serial clock high phase too short");
  sck_low_a: assert property ($fell(sck) |-> !sck [*4])
    else $error("serial clock low phase too short");
  // Data must sit still around the edge that samples it
  sdi_setup_a: assert property ($rose(sck) |-> $stable(sdi) ##1 $stable(sdi))
    else $error("data in moved at rising clock");
  sdo_valid_a: assert property ($fell(sck) && !cs_n |-> $stable(sdo))
    else $error("data out moved at falling clock");
  frame_len_a: assert property ($fell(cs_n) |-> ##[128:200] $rose(cs_n))
    else $error("frame length out of range");

  // Main scenarios reached
  cover property ($fell(cs_n));
  cover property (!sdo_dev_oe_n);
  cover property ($rose(sck) && !cs_n);
endmodule

//--- testbench/amp_tb.sv
`timescale 1ns/1ps
`include "amp_defs.svh"
`define CHK(n, e, s) \
  begin \
    compares++; \
    if ((s) !== (e)) \
    begin \
      fail_count++; \
      $display("MISMATCH %s exp %0h got %0h", n, e, s); \
    end \
  end
module amp_tb;
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic [1:0]  h_addr = 2'h0;
  logic [7:0]  h_wdata = 8'h00;
  logic        h_wr = 1'b0;
  logic        h_rd = 1'b0;
  logic [7:0]  rdata;
  logic        enc_p = 1'b0;
  logic        enc_n = 1'b0;
  logic [15:0] smp1 = 16'h8001;
  logic [15:0] smp2 = 16'h7FFE;
  logic        pd1, pd2, half1, half2, tw1, se1, conv1;
  logic [1:0]  ln1, ln2;
  int          fail_count = 0;
  int          compares = 0;
  int          conv_n = 0;

  amp_port_if link ();
  amp_port_if pl ();

  // Serial pair under test, plus a strapped-parallel end driven by hand
  amp_host amp_host_inst
  (
    .i_clk(i_clk), .i_reset(i_reset), .port(link.host), .i_addr(h_addr),
    .i_wdata(h_wdata), .i_wr(h_wr), .i_rd(h_rd), .o_rdata(rdata)
  );
  amp_device amp_device_inst
  (
    .i_clk(i_clk), .i_reset(i_reset), .port(link.device),
    .i_programming_mode_strap(1'b0), .i_encode_clock_pos(enc_p),
    .i_encode_clock_neg(enc_n), .i_sample_ch1(smp1), .i_sample_ch2(smp2),
    .o_sdo(), .o_sdo_oe_n(), .o_conv_start(conv1), .o_single_ended(se1),
    .o_power_down(pd1), .o_lanes(ln1), .o_drive_half(half1),
    .o_twos_comp(tw1), .o_lane_ch1(), .o_lane_ch2(), .o_lane_valid()
  );
  amp_device amp_device_par_inst
  (
    .i_clk(i_clk), .i_reset(i_reset), .port(pl.device),
    .i_programming_mode_strap(1'b1), .i_encode_clock_pos(enc_p),
    .i_encode_clock_neg(enc_n), .i_sample_ch1(smp1), .i_sample_ch2(smp2),
    .o_sdo(), .o_sdo_oe_n(), .o_conv_start(), .o_single_ended(),
    .o_power_down(pd2), .o_lanes(ln2), .o_drive_half(half2),
    .o_twos_comp(), .o_lane_ch1(), .o_lane_ch2(), .o_lane_valid()
  );
  amp_port_props amp_port_props_inst
  (
    .i_clk(i_clk), .i_reset(i_reset), .cs_n(link.cs_n), .sck(link.sck),
    .sdi(link.sdi), .sdo(link.sdo), .sdo_dev_o(link.sdo_dev_o),
    .sdo_dev_oe_n(link.sdo_dev_oe_n), .sdo_host_o(link.sdo_host_o),
    .sdo_host_oe_n(link.sdo_host_oe_n)
  );

  // Clock and conversion pulse counter
  always #20 i_clk = ~i_clk;
  always @(posedge i_clk)
    if (conv1 === 1'b1)
      conv_n++;

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Register port cycles; a spare cycle keeps strobes from merging
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    h_addr <= a;
    h_wdata <= d;
    h_wr <= 1'b1;
    @(posedge i_clk);
    h_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    h_addr <= a;
    h_rd <= 1'b1;
    @(posedge i_clk);
    h_rd <= 1'b0;
    #1 d = rdata;
    @(posedge i_clk);
  endtask
  // One whole frame, polled until the host goes idle
  task automatic xfer(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] s;
    wr(2'h0, c);
    wr(2'h1, d);
    wr(2'h2, 8'h01);
    s = 8'h01;
    for (int i = 0; i < 150 && s[0] !== 1'b0; i++)
      rd(2'h3, s);
    `CHK("busy", 1'b0, s[0])
    repeat (8) @(posedge i_clk);
  endtask

  task automatic t_write();
    xfer({1'b0, `AMP_REG_OUTMODE}, 8'h06);
    `CHK("lanes", amp_pkg::AMP_LANE_4, ln1)
    `CHK("drive", 1'b1, half1)
    xfer({1'b0, `AMP_REG_FORMAT}, 8'h01);
    `CHK("twos", 1'b1, tw1)
    xfer({1'b0, `AMP_REG_POWER}, 8'h01);
    `CHK("pdown", 1'b1, pd1)
    xfer({1'b0, `AMP_REG_POWER}, 8'h00);
    `CHK("pup", 1'b0, pd1)
    $display("test write done");
  endtask

  task automatic t_read();
    logic [7:0] d;
    xfer({1'b1, `AMP_REG_OUTMODE}, 8'h00);
    rd(2'h2, d);
    `CHK("rb outmode", 8'h06, d)
    xfer({1'b1, `AMP_REG_FORMAT}, 8'h00);
    rd(2'h2, d);
    `CHK("rb format", 8'h01, d)
    `CHK("lanes kept", amp_pkg::AMP_LANE_4, ln1)
    $display("test read done");
  endtask

  // Grounded complement first, then a differential pair
  task automatic t_enc();
    conv_n = 0;
    repeat (5)
    begin
      enc_p <= 1'b1;
      repeat (6) @(posedge i_clk);
      enc_p <= 1'b0;
      repeat (6) @(posedge i_clk);
    end
    `CHK("convs", 5, conv_n)
    `CHK("single", 1'b1, se1)
    enc_n <= 1'b1;
    repeat (8) @(posedge i_clk);
    conv_n = 0;
    repeat (3)
    begin
      enc_p <= 1'b1;
      enc_n <= 1'b0;
      repeat (6) @(posedge i_clk);
      enc_p <= 1'b0;
      enc_n <= 1'b1;
      repeat (6) @(posedge i_clk);
    end
    `CHK("diff", 1'b0, se1)
    `CHK("diff convs", 3, conv_n)
    $display("test encode done");
  endtask

  // Strapped end: pins read as static levels
  task automatic t_par();
    logic [2:0] seen;
    logic       h0;
    seen = 3'h0;
    for (int k = 0; k < 4; k++)
    begin
      pl.cs_n <= k[1];
      pl.sck <= k[0];
      repeat (6) @(posedge i_clk);
      if (ln2 <= 2'h2)
        seen[ln2] = 1'b1;
    end
    `CHK("lane set", 3'h7, seen)
    pl.sdi <= 1'b1;
    repeat (6) @(posedge i_clk);
    `CHK("par pdown", 1'b1, pd2)
    pl.sdi <= 1'b0;
    pl.sdo_host_oe_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    h0 = half2;
    `CHK("par up", 1'b0, pd2)
    `CHK("drive low pin", 1'b0, h0)
    pl.sdo_host_oe_n <= 1'b1;
    repeat (6) @(posedge i_clk);
    `CHK("drive sel", 1'b1, half2)
    `CHK("serial end kept", amp_pkg::AMP_LANE_4, ln1)
    $display("test parallel done");
  endtask

  initial
  begin
    pl.cs_n = 1'b1;
    pl.sck = 1'b0;
    pl.sdi = 1'b0;
    pl.sdo_host_o = 1'b0;
    pl.sdo_host_oe_n = 1'b1;
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    t_write();
    t_read();
    t_enc();
    t_par();
    give_verdict();
  end

  // Watchdog well past the expected run length
  initial
  begin
    #(40 * 20000);
    fail_count++;
    give_verdict();
  end
endmodule
